//--- logic/psc_pkg.sv
// Package for the per-port status and configuration register bank
package psc_pkg;
   localparam int PORT_W = 3;
   localparam int NPORT = 8;
   localparam int ADDR_W = 4;
   localparam int NIB_W = 4;
   localparam int ADDR_HI_BIT = 3;
   // Lower nibble field positions
   localparam int LO_LINK_BIT = 0;
   localparam int LO_COL_BIT = 1;
   localparam int LO_REC_BIT = 2;
   localparam int LO_PARTITION_FLAG_BIT = 3;
   // Upper nibble field positions
   localparam int HI_SQL_BIT = 0;
   localparam int HI_POL_BIT = 1;
   localparam int HI_RSV_BIT = 2;
   localparam int HI_DIS_BIT = 3;
   // Reset values of the writable bits, then the value the reserved bit reads
   localparam logic RST_LINK_OFF = 1'b0;
   localparam logic RST_SQL = 1'b0;
   localparam logic RST_DIS = 1'b0;
   localparam logic RSV_VALUE = 1'b0;
   // Port number of the attachment-unit port
   localparam logic [2:0] AUI_PORT = 3'h1;

   typedef struct packed {
      logic link_pulse_seen;
      logic collision;
      logic receive_source;
      logic partitioned;
      logic polarity_inverted;
      logic internal_xcvr;
   } psc_status_t;

   typedef struct packed {
      logic link_test_off;
      logic squelch_reduce;
      logic port_disable;
      logic partition_reset;
   } psc_ctrl_t;
endpackage : psc_pkg

//--- logic/psc_port_regs.sv
// Per-port status and configuration register bank, nibble wide
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Lower bit 0 reads zero while link pulses arrive, one otherwise.
// - Writing one there stops link pulse transmit and monitoring.
// - Link bit undefined on port 1 or with external transceivers.
// - Lower bit 1 reads zero when a collision occurred this packet.
// - Lower bit 2 reads zero when port was receive source this packet.
// - Lower bit 3 reads zero while partitioned, one when connected.
// - Writing one to partition bit resets partition machine; zero ignored.
// - Upper bit 0 selects normal (0) or reduced (1) squelch threshold.
// - Squelch select has no effect with external transceiver.
// - Upper bit 2 is reserved and reads zero.
// - Upper bit 3 set blocks all port activity.
// - Address: low three bits pick port, top bit picks upper nibble.
module psc_port_regs
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [3:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] link_pulse_seen,
   input wire logic [7:0] collision,
   input wire logic [7:0] receive_source,
   input wire logic [7:0] partitioned,
   input wire logic [7:0] polarity_inverted,
   input wire logic [7:0] internal_xcvr,
   output logic [3:0] rd_data,
   output logic rd_valid,
   output logic [7:0] link_test_off,
   output logic [7:0] squelch_reduce,
   output logic [7:0] port_disable,
   output logic [7:0] partition_reset
);

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   // Status comes from port logic in other timing; two stages before use
   // Only the second stage feeds logic; the first may still be settling
   psc_pkg::psc_status_t [7:0] meta_ff, sync_ff, nxt_meta, nxt_sync;

   always_comb
   begin
      for (int i = 0; i < psc_pkg::NPORT; i++)
      begin
         nxt_meta[i] = {link_pulse_seen[i], collision[i], receive_source[i],
                        partitioned[i], polarity_inverted[i], internal_xcvr[i]};
         nxt_sync[i] = meta_ff[i];
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         meta_ff <= '0;
         sync_ff <= '0;
      end
      else
      begin
         meta_ff <= nxt_meta;
         sync_ff <= nxt_sync;
      end
   end

   // ****************************************************************
   // Address decode
   // ****************************************************************
   function automatic logic is_upper(input logic [3:0] a);
      is_upper = a[psc_pkg::ADDR_HI_BIT];
   endfunction : is_upper

   function automatic logic [2:0] port_of(input logic [3:0] a);
      port_of = a[psc_pkg::PORT_W-1:0];
   endfunction : port_of

   // Port field zero is the device-wide register, which lives elsewhere
   function automatic logic is_port_sel(input logic [3:0] a);
      is_port_sel = (port_of(a) != 3'h0);
   endfunction : is_port_sel

   // ****************************************************************
   // Control state and read path
   // ****************************************************************
   psc_pkg::psc_ctrl_t [7:0] ctrl_ff, nxt_ctrl;
   logic [3:0] rd_data_ff, nxt_rd_data;
   logic rd_valid_ff, nxt_rd_valid;

   always_comb
   begin
      logic [2:0] p;
      psc_pkg::psc_status_t s;
      p = port_of(reg_addr);
      s = sync_ff[p];
      nxt_ctrl = ctrl_ff;
      nxt_rd_data = rd_data_ff;
      nxt_rd_valid = 1'b0;
      // Reset request lasts one cycle only
      for (int i = 0; i < psc_pkg::NPORT; i++)
      begin
         nxt_ctrl[i].partition_reset = 1'b0;
      end
      // A write of zero to the partition bit only leaves the pulse low
      if (wr_stb && is_port_sel(reg_addr))
      begin
         if (is_upper(reg_addr))
         begin
            // Polarity and reserved bits are not stored
            nxt_ctrl[p].squelch_reduce = wr_data[psc_pkg::HI_SQL_BIT];
            nxt_ctrl[p].port_disable = wr_data[psc_pkg::HI_DIS_BIT];
         end
         else
         begin
            // Bits 1 and 2 of the lower nibble are status only
            nxt_ctrl[p].link_test_off = wr_data[psc_pkg::LO_LINK_BIT];
            nxt_ctrl[p].partition_reset = wr_data[psc_pkg::LO_PARTITION_FLAG_BIT];
         end
      end
      // Read and write in one cycle: the read returns the old control value
      // rd_data keeps the last answer so a slow reader may sample late
      if (rd_stb && is_port_sel(reg_addr))
      begin
         nxt_rd_valid = 1'b1;
         if (is_upper(reg_addr))
         begin
            // Polarity is live status; squelch and disable are stored selects
            nxt_rd_data[psc_pkg::HI_SQL_BIT] = ctrl_ff[p].squelch_reduce;
            nxt_rd_data[psc_pkg::HI_POL_BIT] = s.polarity_inverted;
            nxt_rd_data[psc_pkg::HI_RSV_BIT] = psc_pkg::RSV_VALUE;
            nxt_rd_data[psc_pkg::HI_DIS_BIT] = ctrl_ff[p].port_disable;
         end
         else
         begin
            // Meaningless on port 1 or external transceivers
            nxt_rd_data[psc_pkg::LO_LINK_BIT] = ~s.link_pulse_seen;
            nxt_rd_data[psc_pkg::LO_COL_BIT] = ~s.collision;
            nxt_rd_data[psc_pkg::LO_REC_BIT] = ~s.receive_source;
            nxt_rd_data[psc_pkg::LO_PARTITION_FLAG_BIT] = ~s.partitioned;
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         // Ports come up enabled, with normal squelch and link test on
         for (int i = 0; i < psc_pkg::NPORT; i++)
         begin
            ctrl_ff[i].link_test_off <= psc_pkg::RST_LINK_OFF;
            ctrl_ff[i].squelch_reduce <= psc_pkg::RST_SQL;
            ctrl_ff[i].port_disable <= psc_pkg::RST_DIS;
            ctrl_ff[i].partition_reset <= 1'b0;
         end
         rd_data_ff <= 4'h0;
         rd_valid_ff <= 1'b0;
      end
      else
      begin
         ctrl_ff <= nxt_ctrl;
         rd_data_ff <= nxt_rd_data;
         rd_valid_ff <= nxt_rd_valid;
      end
   end

   // ****************************************************************
   // Port control outputs
   // ****************************************************************
   // A second flop stage keeps every output straight from a register;
   // control therefore reaches the port two cycles after the write
   logic [7:0] lto_ff, sqr_ff, dis_ff, prs_ff;
   logic [7:0] nxt_lto, nxt_sqr, nxt_dis, nxt_prs;

   always_comb
   begin
      for (int i = 0; i < psc_pkg::NPORT; i++)
      begin
         nxt_lto[i] = ctrl_ff[i].link_test_off;
         // Squelch matters only to the internal transceiver
         // Gating on the synchronised select avoids glitches on a mode change
         nxt_sqr[i] = ctrl_ff[i].squelch_reduce & sync_ff[i].internal_xcvr;
         nxt_dis[i] = ctrl_ff[i].port_disable;
         nxt_prs[i] = ctrl_ff[i].partition_reset;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         lto_ff <= 8'h00;
         sqr_ff <= 8'h00;
         dis_ff <= 8'h00;
         prs_ff <= 8'h00;
      end
      else
      begin
         lto_ff <= nxt_lto;
         sqr_ff <= nxt_sqr;
         dis_ff <= nxt_dis;
         prs_ff <= nxt_prs;
      end
   end

   // ****************************************************************
   // Output wiring
   // ****************************************************************
   assign rd_data = rd_data_ff;
   assign rd_valid = rd_valid_ff;
   assign link_test_off = lto_ff;
   assign squelch_reduce = sqr_ff;
   assign port_disable = dis_ff;
   assign partition_reset = prs_ff;

endmodule : psc_port_regs
`default_nettype wire

//--- sim/psc_port_regs_sva.sv
// Assertion checker for the port register bank
`timescale 1ns/100ps
`default_nettype none
module psc_port_regs_sva
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [3:0] wr_data,
   input wire logic wr_stb,
   input wire logic rd_stb,
   input wire logic [7:0] internal_xcvr,
   input wire logic [3:0] rd_data,
   input wire logic rd_valid,
   input wire logic [7:0] link_test_off,
   input wire logic [7:0] squelch_reduce,
   input wire logic [7:0] port_disable,
   input wire logic [7:0] partition_reset
);
   // ****************
   // Checks
   // ****************
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   AST_RD_ACK: assert property (rd_stb && reg_addr[2:0] != 3'h0 |=> rd_valid)
      else $error("read not answered");
   AST_RD_SRC: assert property (rd_valid |-> $past(rd_stb) && $past(reg_addr[2:0]) != 3'h0)
      else $error("stray read answer");
   AST_RSV: assert property (rd_stb && reg_addr[3] && reg_addr[2:0] != 3'h0 |=> !rd_data[2])
      else $error("reserved bit set");
   AST_DIS: assert property (wr_stb && reg_addr == 4'hb |-> ##2 port_disable[3] == $past(wr_data[3], 2))
      else $error("disable not written");
   AST_LINK: assert property (wr_stb && reg_addr == 4'h5 |-> ##2 link_test_off[5] == $past(wr_data[0], 2))
      else $error("link test not written");
   AST_PRST: assert property (wr_stb && reg_addr == 4'h5 && wr_data[3] |-> ##2 partition_reset[5])
      else $error("partition reset missing");
   AST_PRST0: assert property (wr_stb && (reg_addr[3] || !wr_data[3]) |-> ##2 partition_reset == 8'h00)
      else $error("spurious partition reset");
   AST_SQL_EXT: assert property ((internal_xcvr == 8'h00) [*4] |-> squelch_reduce == 8'h00)
      else $error("squelch active on external port");
endmodule : psc_port_regs_sva
bind psc_port_regs psc_port_regs_sva chk_i (.clk_sys, .rst_n, .reg_addr, .wr_data, .wr_stb, .rd_stb,
   .internal_xcvr, .rd_data, .rd_valid, .link_test_off, .squelch_reduce, .port_disable,
   .partition_reset);
`default_nettype wire

//--- sim/psc_cpu_model.sv
// Microprocessor model for the nibble-wide port registers
`timescale 1ns/100ps
`default_nettype none
module psc_cpu_model
(
   input wire logic clk_sys,
   output var logic [3:0] reg_addr = 4'h0,
   output var logic [3:0] wr_data = 4'h0,
   output var logic wr_stb = 1'b0,
   output var logic rd_stb = 1'b0,
   input wire logic [3:0] rd_data
);
   // ****************
   // Accesses, one strobe cycle each
   // ****************
   task automatic wr(input logic [3:0] a, input logic [3:0] d);
      @(posedge clk_sys);
      #1;
      reg_addr = a;
      wr_data = d;
      wr_stb = 1'b1;
      @(posedge clk_sys);
      #1;
      wr_stb = 1'b0;
      wr_data = ~d; // Released data must not keep the written value
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [3:0] d);
      @(posedge clk_sys);
      #1;
      reg_addr = a;
      rd_stb = 1'b1;
      @(posedge clk_sys);
      #1;
      rd_stb = 1'b0;
      d = rd_data;
   endtask : rd
endmodule : psc_cpu_model
`default_nettype wire

//--- sim/port_status_config_regs_tb.sv
// Testbench for the port register bank
`timescale 1ns/100ps
`default_nettype none
module port_status_config_regs_tb;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [47:0] st = 48'h0; // xcvr, polarity, partition, source, collision, link
   logic [3:0] reg_addr, wr_data, rd_data;
   logic wr_stb, rd_stb, rd_valid;
   logic [7:0] lto, sqr, pdis, prs;
   int num_errors = 0;
   int samples_checked = 0;
   always #2 clk_sys = ~clk_sys;
   psc_cpu_model cpu (.clk_sys, .reg_addr, .wr_data, .wr_stb, .rd_stb, .rd_data);
   psc_port_regs uut (.clk_sys, .rst_n, .reg_addr, .wr_data, .wr_stb, .rd_stb,
      .link_pulse_seen(st[7:0]), .collision(st[15:8]), .receive_source(st[23:16]),
      .partitioned(st[31:24]), .polarity_inverted(st[39:32]), .internal_xcvr(st[47:40]),
      .rd_data, .rd_valid, .link_test_off(lto), .squelch_reduce(sqr), .port_disable(pdis),
      .partition_reset(prs));
   // ****************
   // Scenarios
   // ****************
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : step
   task automatic t_status;
      logic [3:0] d;
      logic [7:0] e;
      chk(lto | sqr | pdis | prs, 8'h00);
      st = 48'hfd_99_c6_0f_33_5a;
      step(3);
      for (int p = 1; p < 8; p++)
      begin
         cpu.rd({1'b0, p[2:0]}, d);
         d[0] = (p == 1) ? ~st[p] : d[0]; // Link bit carries nothing on the AUI port
         e = {4'h0, ~st[24+p], ~st[16+p], ~st[8+p], ~st[p]};
         chk({4'h0, d}, e);
         chk({7'h00, rd_valid}, 8'h01);
         cpu.rd({1'b1, p[2:0]}, d);
         chk({4'h0, d}, {6'h00, st[32+p], 1'b0});
      end
      cpu.rd(4'h0, d);
      chk({7'h00, rd_valid}, 8'h00);
   endtask : t_status
   task automatic t_ctrl;
      logic [3:0] d;
      st[47:40] = 8'h0d;
      step(3);
      cpu.wr(4'hb, 4'hf);
      cpu.wr(4'hc, 4'hf);
      step(1);
      chk(pdis, 8'h18);
      chk(sqr, 8'h08);
      cpu.rd(4'hb, d);
      chk({4'h0, d}, 8'h0b);
      cpu.wr(4'ha, 4'h6);
      cpu.rd(4'ha, d);
      chk({4'h0, d}, 8'h00);
      cpu.wr(4'h5, 4'h9);
      step(1);
      chk(prs, 8'h20);
      chk(lto, 8'h20);
      step(1);
      chk(prs, 8'h00);
      cpu.wr(4'h5, 4'h6);
      step(1);
      chk(prs | lto, 8'h00);
      st[47:40] = 8'h00;
      step(5);
      chk(sqr, 8'h00);
   endtask : t_ctrl
   task automatic t_reset;
      logic [3:0] d;
      rst_n = 1'b0;
      step(2);
      rst_n = 1'b1;
      chk(pdis | sqr | lto | prs, 8'h00);
      step(3);
      cpu.rd(4'hb, d);
      chk({4'h0, d}, 8'h02);
   endtask : t_reset
   task automatic end_of_test;
      $display("checks %0d, errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test
   initial
   begin
      step(8);
      rst_n = 1'b1;
      t_status();
      t_ctrl();
      t_reset();
      end_of_test();
   end
endmodule : port_status_config_regs_tb
`default_nettype wire
